/* File: core/disk_status_flags.sv */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - after a command write, busy or data request stays set until completion or release
// - data request rises, with busy cleared, when a PIO word is ready to move
// - during a DMA data phase busy and data request are both held set
// - data request clears on the last word of the data transfer
// - for a packet command data request clears on the last packet word
// - error flag sets when the command fails while busy or data request is set outside the soft-reset phase
// - for packet and service commands the error bit means check condition
// - error register content is valid whenever the error flag reads one
// - error flag freezes the error register, and the task registers against device loads, until new command or reset
// - error flag clears on new command, soft reset bit, or hardware reset
// - on unrecoverable error the engine's error outputs land in the task registers
// - a status read clears a pending interrupt
// - status is read-only; a write to its address writes the command register
module disk_status_flags
   import disk_status_pkg::*;
#(
   parameter int PACKET_WORDS = PKT_WORDS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cmdValid,
   output cmdParams_t cmdParams,
   input wire logic engXferReq,
   input wire xferKind_t engXferKind,
   input wire logic [CNT_W-1:0] engWords,
   input wire logic engDone,
   input wire logic engRelease,
   input wire logic engFail,
   input wire logic [7:0] engErrCode,
   input wire taskBytes_t engResult,
   output logic pioStrobe,
   output logic pioWrite,
   output logic [15:0] pioWrData,
   input wire logic [15:0] pioRdData,
   output logic packetDone,
   output logic dmarq,
   input wire logic dmackN,
   input wire logic dmaWordDone,
   output flags_t flags,
   output logic intrq
);

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_BUSY,
      PH_PIO,
      PH_PACKET,
      PH_DMA,
      PH_SOFTCLR
   } phase_t;

   phase_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] error_r, features_r, devCtrl_r, cmdCode_r;
   logic errFlag_r, errFlag_nxt;
   logic intPend_r;
   logic dmackMeta_r, dmackSync_r;
   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;
   logic cmdValid_r, pioStrobe_r, pioWrite_r, packetDone_r, dmarq_r;
   logic [15:0] pioWrData_r;
   flags_t flags_r;
   taskBytes_t taskVal;

   // bus decode
   logic setup, access, wrAcc, rdAcc;
   logic hitData, hitError, hitStatus, hitDevCtrl, hitTask, mapped;
   logic [ADDR_W-1:0] taskOfs;
   logic [2:0] taskIdx;
   logic idle, softRst;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_r;
   assign wrAcc = access & pwrite;
   assign rdAcc = access & ~pwrite;
   assign taskOfs = paddr - OFS_TASK0;
   assign taskIdx = taskOfs[4:2];
   assign hitData = paddr == OFS_DATA;
   assign hitError = paddr == OFS_ERROR;
   assign hitStatus = paddr == OFS_STATUS;
   assign hitDevCtrl = paddr == OFS_DEVCTRL;
   assign hitTask = (paddr >= OFS_TASK0) && (paddr < OFS_STATUS) && (paddr[1:0] == 2'b00);
   assign mapped = hitData | hitError | hitStatus | hitDevCtrl | hitTask;
   assign idle = state_r == PH_IDLE;
   assign softRst = devCtrl_r[DC_SOFTRST];

   // command acceptance: busy or data request ignores all but the device reset code
   logic cmdWr, cmdAccept, pktCmd;
   assign cmdWr = wrAcc & hitStatus;
   assign cmdAccept = cmdWr & ~softRst & (idle | (pwdata[7:0] == CMD_DEVRESET));
   assign pktCmd = pwdata[7:0] == CMD_PACKET;

   // data-phase word events
   logic pioAcc, dmaWord, lastWord, inData;
   assign inData = (state_r == PH_PIO) | (state_r == PH_PACKET);
   assign pioAcc = access & hitData & inData;
   assign dmaWord = (state_r == PH_DMA) & dmaWordDone & ~dmackSync_r;
   assign lastWord = cnt_r == CNT_W'(1);

   // failure counts only while busy or data request is up outside the soft-reset phase (PH_SOFTCLR)
   logic failEv, doneEv, errLoad, normLoad;
   assign failEv = engFail & ~idle & (state_r != PH_SOFTCLR);
   assign doneEv = engDone & (state_r == PH_BUSY);
   assign errLoad = failEv;
   assign normLoad = doneEv & ~errFlag_r;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      errFlag_nxt = errFlag_r;
      if (softRst) begin
         state_nxt = PH_SOFTCLR;
         errFlag_nxt = 1'b0;
      end else if (cmdAccept) begin
         errFlag_nxt = 1'b0;
         if (pktCmd) begin
            state_nxt = PH_PACKET;
            cnt_nxt = CNT_W'(PACKET_WORDS);
         end else begin
            state_nxt = PH_BUSY;
         end
      end else if (failEv) begin
         state_nxt = PH_IDLE;
         errFlag_nxt = 1'b1;
      end else begin
         unique case (state_r)
            PH_IDLE: begin
               state_nxt = PH_IDLE;
            end
            PH_SOFTCLR: begin
               state_nxt = PH_IDLE;
            end
            PH_BUSY: begin
               if (engXferReq && engWords != '0) begin
                  state_nxt = (engXferKind == XFER_DMA) ? PH_DMA : PH_PIO;
                  cnt_nxt = engWords;
               end else if (engDone || engRelease) begin
                  state_nxt = PH_IDLE;
               end
            end
            PH_PIO, PH_PACKET: begin
               if (pioAcc) begin
                  cnt_nxt = cnt_r - CNT_W'(1);
                  if (lastWord) begin
                     state_nxt = PH_BUSY;
                  end
               end
            end
            PH_DMA: begin
               if (dmaWord) begin
                  cnt_nxt = cnt_r - CNT_W'(1);
                  if (lastWord) begin
                     state_nxt = PH_BUSY;
                  end
               end
            end
            default: begin
               state_nxt = PH_IDLE;
            end
         endcase
      end
   end

   // flag outputs follow the next phase so they stand with it
   flags_t flagsNxt;
   assign flagsNxt.busy = (state_nxt == PH_BUSY) | (state_nxt == PH_SOFTCLR) |
                          (state_nxt == PH_DMA);
   assign flagsNxt.dataReq = (state_nxt == PH_PIO) | (state_nxt == PH_PACKET) |
                             (state_nxt == PH_DMA);
   assign flagsNxt.err = errFlag_nxt;

   // interrupt raised when a PIO data block is ready or the command completes or fails
   logic intSet, intClr;
   assign intSet = (doneEv | failEv | (state_r == PH_BUSY && state_nxt == PH_PIO)) & ~softRst;
   assign intClr = rdAcc & hitStatus;

   // the error bit doubles as check condition for packet and service commands
   logic [7:0] statusByte;
   always_comb begin
      statusByte = 8'h00;
      statusByte[ST_BUSY] = flags_r.busy;
      statusByte[ST_DATAREQ] = flags_r.dataReq;
      statusByte[ST_ERR] = flags_r.err;
   end

   logic [7:0] rdByte;
   logic [31:0] rdWord;
   always_comb begin
      rdByte = 8'h00;
      if (hitError) begin
         rdByte = error_r;
      end else if (hitTask) begin
         rdByte = taskVal[taskIdx];
      end else if (hitStatus || hitDevCtrl) begin
         rdByte = statusByte;
      end
      rdWord = hitData ? {16'h0000, pioRdData} : {24'h00_0000, rdByte};
   end

   // task registers: host writes only when idle, device loads gated by the freeze
   genvar gi;
   generate
      for (gi = 0; gi < TASK_REGS; gi++) begin : g_task
         logic hostWrThis;
         assign hostWrThis = wrAcc & hitTask & idle & (taskIdx == 3'(gi));
         task_byte_reg u_reg (
            .mclk(mclk),
            .reset(reset),
            .softClr(softRst),
            .hostWr(hostWrThis),
            .hostData(pwdata[7:0]),
            .devLoad(errLoad | normLoad),
            .frozen(errFlag_r),
            .devData(engResult[gi]),
            .value(taskVal[gi])
         );
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= PH_IDLE;
         cnt_r <= '0;
         errFlag_r <= 1'b0;
         flags_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         errFlag_r <= errFlag_nxt;
         flags_r <= flagsNxt;
      end
   end

   // error register only changes on a failure or a reset, so it stays frozen after a failure
   always_ff @(posedge mclk) begin
      if (reset || softRst) begin
         error_r <= ERROR_RST;
      end else if (errLoad && !errFlag_r) begin
         error_r <= engErrCode;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         devCtrl_r <= DEVCTRL_RST;
         features_r <= TASK_RST;
         cmdCode_r <= 8'h00;
      end else begin
         if (wrAcc && hitDevCtrl) begin
            devCtrl_r <= pwdata[7:0];
         end
         if (wrAcc && hitError && idle) begin
            features_r <= pwdata[7:0];
         end
         if (cmdAccept) begin
            cmdCode_r <= pwdata[7:0];
         end
      end
   end

   // a set in the same cycle as a status read keeps the interrupt pending
   always_ff @(posedge mclk) begin
      if (reset || softRst) begin
         intPend_r <= 1'b0;
      end else if (intSet) begin
         intPend_r <= 1'b1;
      end else if (intClr) begin
         intPend_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dmackMeta_r <= 1'b1;
         dmackSync_r <= 1'b1;
      end else begin
         dmackMeta_r <= dmackN;
         dmackSync_r <= dmackMeta_r;
      end
   end

   // bus answer: data latched at setup, pready high in the first access cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         prdata_r <= (setup && !pwrite) ? rdWord : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cmdValid_r <= 1'b0;
         pioStrobe_r <= 1'b0;
         pioWrite_r <= 1'b0;
         pioWrData_r <= 16'h0000;
         packetDone_r <= 1'b0;
         dmarq_r <= 1'b0;
      end else begin
         cmdValid_r <= cmdAccept;
         pioStrobe_r <= pioAcc;
         pioWrite_r <= pioAcc ? pwrite : pioWrite_r;
         pioWrData_r <= (pioAcc && pwrite) ? pwdata[15:0] : pioWrData_r;
         packetDone_r <= pioAcc & lastWord & (state_r == PH_PACKET);
         dmarq_r <= state_nxt == PH_DMA;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign cmdValid = cmdValid_r;
   assign cmdParams.code = cmdCode_r;
   assign cmdParams.features = features_r;
   assign cmdParams.taskRegs = taskVal;
   assign pioStrobe = pioStrobe_r;
   assign pioWrite = pioWrite_r;
   assign pioWrData = pioWrData_r;
   assign packetDone = packetDone_r;
   assign dmarq = dmarq_r;
   assign flags = flags_r;
   assign intrq = intPend_r;

endmodule

/* File: core/disk_status_pkg.sv */
package disk_status_pkg;

   localparam int ADDR_W = 8;
   localparam int TASK_REGS = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ERROR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TASK0 = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_DEVCTRL = 8'h20;

   // task register indices, at OFS_TASK0 + 4 * index
   localparam int TR_SECCNT = 0;
   localparam int TR_SECNUM = 1;
   localparam int TR_CYLLO = 2;
   localparam int TR_CYLHI = 3;
   localparam int TR_DEVHEAD = 4;

   // status byte fields
   localparam int ST_BUSY = 7;
   localparam int ST_DATAREQ = 3;
   localparam int ST_ERR = 0;

   // device control fields
   localparam int DC_SOFTRST = 2;

   // command codes
   localparam logic [7:0] CMD_PACKET = 8'hA0;
   localparam logic [7:0] CMD_SERVICE = 8'hA2;
   localparam logic [7:0] CMD_DEVRESET = 8'h08;

   // reset values
   localparam logic [7:0] ERROR_RST = 8'h00;
   localparam logic [7:0] TASK_RST = 8'h00;
   localparam logic [7:0] DEVCTRL_RST = 8'h00;

   // command packet length in 16-bit words
   localparam int PKT_WORDS = 6;
   localparam int CNT_W = 16;

   typedef logic [TASK_REGS-1:0][7:0] taskBytes_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] features;
      taskBytes_t taskRegs;
   } cmdParams_t;

   typedef struct packed {
      logic busy;
      logic dataReq;
      logic err;
   } flags_t;

   typedef enum logic [1:0] {
      XFER_PIO_IN,
      XFER_PIO_OUT,
      XFER_DMA
   } xferKind_t;

endpackage

/* File: core/task_byte_reg.sv */
`timescale 1ns/1ps
module task_byte_reg
   import disk_status_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic softClr,
   input wire logic hostWr,
   input wire logic [7:0] hostData,
   input wire logic devLoad,
   input wire logic frozen,
   input wire logic [7:0] devData,
   output logic [7:0] value
);

   logic [7:0] value_r;
   logic devTake;

   // device-side update is blocked while the error outputs must stand
   assign devTake = devLoad & ~frozen;
   assign value = value_r;

   always_ff @(posedge mclk) begin
      if (reset || softClr) begin
         value_r <= TASK_RST;
      end else if (devTake) begin
         value_r <= devData;
      end else if (hostWr) begin
         value_r <= hostData;
      end
   end

endmodule

/* File: bench/disk_status_flags_asserts.sv */
`timescale 1ns/1ps
module disk_status_flags_asserts
   import disk_status_pkg::*;
#(
   parameter int PACKET_WORDS = PKT_WORDS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmdValid,
   input wire cmdParams_t cmdParams,
   input wire logic engXferReq,
   input wire logic engDone,
   input wire logic engFail,
   input wire logic packetDone,
   input wire logic dmarq,
   input wire flags_t flags,
   input wire logic intrq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   wire logic acc = psel && penable && pready && !pslverr;
   wire logic stW = acc && pwrite && paddr == OFS_STATUS;
   wire logic stR = acc && !pwrite && paddr == OFS_STATUS;
   wire logic idle = !flags.busy && !flags.dataReq;
   wire logic noSet = !engFail && !engDone && !engXferReq;
   AST_CMD_HOLD: assert property (stW && idle |=> flags.busy || flags.dataReq)
      else $error("command left no busy or data request");
   AST_CMD_TAKE: assert property (
      stW && idle |=> cmdValid && cmdParams.code == $past(pwdata[7:0]))
      else $error("status write not taken as command");
   AST_DREQ_BUSY: assert property (
      $rose(flags.dataReq) && !$past(stW) |-> $past(flags.busy))
      else $error("data request rose without busy");
   AST_DMA_BOTH: assert property (dmarq |-> flags.busy && flags.dataReq)
      else $error("dma phase lost busy or data request");
   AST_PKT_END: assert property ($rose(packetDone) |-> !flags.dataReq)
      else $error("data request held after packet");
   AST_ERR_SET: assert property (
      engFail && !idle |=> flags.err && !flags.busy && !flags.dataReq)
      else $error("failure not flagged");
   AST_FREEZE: assert property (
      flags.err && !psel |=> $stable(cmdParams.taskRegs) || !flags.err)
      else $error("task registers moved while frozen");
   AST_ERR_CLR: assert property (stW && idle && flags.err |=> !flags.err)
      else $error("error flag kept after command");
   AST_INT_CLR: assert property (stR && intrq && noSet |=> !intrq)
      else $error("status read kept interrupt");
   AST_STAT_MAP: assert property (stR |-> prdata == {24'h00_0000, $past(flags.busy),
      3'h0, $past(flags.dataReq), 2'h0, $past(flags.err)})
      else $error("status byte layout wrong");
endmodule

/* File: bench/host_adapter.sv */
`timescale 1ns/1ps
module host_adapter
   import disk_status_pkg::*;
(
   input wire logic mclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released bus must not keep showing the old data
      pwdata <= ~d;
   endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
bind disk_status_flags disk_status_flags_asserts #(.PACKET_WORDS(PACKET_WORDS)) u_check (
   .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmdValid(cmdValid), .cmdParams(cmdParams), .engXferReq(engXferReq), .engDone(engDone),
   .engFail(engFail), .packetDone(packetDone), .dmarq(dmarq), .flags(flags), .intrq(intrq));
module testbench
   import disk_status_pkg::*;
;
   localparam int PW = 3;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, cmdValid, pioStrobe, pioWrite;
   logic packetDone, dmarq, intrq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] pioWrData;
   cmdParams_t cmdParams;
   flags_t flags;
   logic engXferReq = 1'b0, engDone = 1'b0, engFail = 1'b0;
   logic dmackN = 1'b1, dmaWordDone = 1'b0;
   xferKind_t engXferKind = XFER_PIO_IN;
   logic [CNT_W-1:0] engWords = 16'h0002;
   logic [7:0] engErrCode = 8'h04;
   taskBytes_t engResult = 40'h11_2233_4455;
   logic [15:0] pioRdData = 16'hBEEF;
   int err_total = 0;
   int cmp_count = 0;
   always #50 mclk = ~mclk;
   disk_status_flags #(.PACKET_WORDS(PW)) u_dut (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmdValid(cmdValid), .cmdParams(cmdParams), .engXferReq(engXferReq),
      .engXferKind(engXferKind), .engWords(engWords), .engDone(engDone), .engRelease(1'b0),
      .engFail(engFail), .engErrCode(engErrCode), .engResult(engResult),
      .pioStrobe(pioStrobe), .pioWrite(pioWrite), .pioWrData(pioWrData),
      .pioRdData(pioRdData), .packetDone(packetDone), .dmarq(dmarq), .dmackN(dmackN),
      .dmaWordDone(dmaWordDone), .flags(flags), .intrq(intrq));
   host_adapter u_host (
      .mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   task automatic compare(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
      compare("read", exp, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic fl(input logic [2:0] e);
      #1;
      compare("flags", {29'h0, e}, {29'h0, flags});
   endtask
   // ev bits: fail, done, transfer request
   task automatic eng(input logic [2:0] ev);
      @(posedge mclk);
      {engFail, engDone, engXferReq} <= ev;
      @(posedge mclk);
      {engFail, engDone, engXferReq} <= 3'h0;
   endtask
   task automatic t_idle();
      logic [31:0] q;
      logic e;
      rd(OFS_STATUS, 32'h0000_0000);
      rd(OFS_ERROR, 32'h0000_0000);
      u_host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
      compare("unmapped", 32'h0000_0001, {31'h0, e});
      wr(OFS_TASK0, 32'h0000_005A);
      rd(OFS_TASK0, 32'h0000_005A);
      wr(OFS_ERROR, 32'h0000_003C);
      #1;
      compare("features", 32'h0000_003C, {24'h00_0000, cmdParams.features});
      rd(OFS_ERROR, 32'h0000_0000);
      $display("test idle done");
   endtask
   task automatic t_pio();
      wr(OFS_STATUS, 32'h0000_0020);
      fl(3'h4);
      eng(3'h1);
      fl(3'h2);
      rd(OFS_STATUS, 32'h0000_0008);
      #1;
      compare("intrq", 32'h0000_0000, {31'h0, intrq});
      rd(OFS_DATA, 32'h0000_BEEF);
      rd(OFS_DATA, 32'h0000_BEEF);
      fl(3'h4);
      compare("pioStrobe", 32'h0000_0001, {31'h0, pioStrobe});
      compare("pioWrite", 32'h0000_0000, {31'h0, pioWrite});
      eng(3'h4);
      fl(3'h1);
      rd(OFS_ERROR, 32'h0000_0004);
      rd(OFS_TASK0 + 8'h10, 32'h0000_0011);
      engResult <= 40'hAA_AAAA_AAAA;
      eng(3'h2);
      rd(OFS_TASK0, 32'h0000_0055);
      wr(OFS_STATUS, 32'h0000_0020);
      fl(3'h4);
      eng(3'h2);
      fl(3'h0);
      $display("test pio done");
   endtask
   task automatic t_pkt();
      wr(OFS_STATUS, {24'h00_0000, CMD_PACKET});
      fl(3'h2);
      repeat (PW) wr(OFS_DATA, 32'h0000_1234);
      fl(3'h4);
      compare("packetDone", 32'h0000_0001, {31'h0, packetDone});
      compare("pioWrite", 32'h0000_0001, {31'h0, pioWrite});
      compare("pioWrData", 32'h0000_1234, {16'h0000, pioWrData});
      eng(3'h4);
      fl(3'h1);
      wr(OFS_DEVCTRL, 32'h0000_0004);
      @(posedge mclk);
      fl(3'h4);
      rd(OFS_DEVCTRL, 32'h0000_0080);
      rd(OFS_ERROR, 32'h0000_0000);
      wr(OFS_DEVCTRL, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      fl(3'h0);
      $display("test packet done");
   endtask
   task automatic t_dma();
      wr(OFS_STATUS, 32'h0000_00C8);
      engXferKind <= XFER_DMA;
      eng(3'h1);
      fl(3'h6);
      compare("dmarq", 32'h0000_0001, {31'h0, dmarq});
      @(posedge mclk);
      dmackN <= 1'b0;
      repeat (3) @(posedge mclk);
      repeat (2) begin
         dmaWordDone <= 1'b1;
         @(posedge mclk);
         dmaWordDone <= 1'b0;
         @(posedge mclk);
      end
      dmackN <= 1'b1;
      repeat (2) @(posedge mclk);
      fl(3'h4);
      eng(3'h2);
      fl(3'h0);
      $display("test dma done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200_000;
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_idle();
      t_pio();
      t_pkt();
      t_dma();
      wrap_up();
   end
endmodule
